/* File: hdl/scd_pkg.sv */
// shared constants, types and helpers of the system clock divider block
package scd_pkg;

  // ----------------------------------------------------------------
  // cpu divider codes
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_CODE_BY8 = 3'h0;
  localparam logic [2:0] DIV_CODE_BY4 = 3'h1;
  localparam logic [2:0] DIV_CODE_BY2 = 3'h2;
  localparam logic [2:0] DIV_CODE_BY1 = 3'h3;
  localparam logic [2:0] DIV_CODE_BAD_A = 3'h4;
  localparam logic [2:0] DIV_CODE_BAD_B = 3'h5;
  localparam logic [2:0] DIV_CODE_BY16 = 3'h6;
  localparam logic [2:0] DIV_CODE_BY32 = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_CODE_RESET = DIV_CODE_BY2;
  localparam logic [1:0] LOAD_PULL_RESET = 2'h0;
  localparam logic [2:0] BIAS_TRIM_RESET = 3'h0;
  localparam logic SRC_RC_RESET = 1'b1;
  localparam logic TARGET_RC_RESET = 1'b0;
  localparam logic PD_POLICY_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 50;
  localparam int XTAL_STARTUP_NS = 1000000;
  localparam int XTAL_STARTUP_CYC =
    (XTAL_STARTUP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [4:0] PERIPH_DIV_LAST = 5'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [4:0] scd_count_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count value of one cpu clock period for a code
  function automatic scd_count_t scd_div_last(input logic [2:0] code);
    scd_count_t last;
    last = 5'h00;
    case (code)
      DIV_CODE_BY8: last = 5'h07;
      DIV_CODE_BY4: last = 5'h03;
      DIV_CODE_BY2: last = 5'h01;
      DIV_CODE_BY1: last = 5'h00;
      DIV_CODE_BY16: last = 5'h0f;
      DIV_CODE_BY32: last = 5'h1f;
      default: last = 5'h01;
    endcase
    return last;
  endfunction : scd_div_last

  // codes that name no divisor
  function automatic logic scd_code_bad(input logic [2:0] code);
    return (code == DIV_CODE_BAD_A) || (code == DIV_CODE_BAD_B);
  endfunction : scd_code_bad

endpackage : scd_pkg

/* File: hdl/scd_edge_sync.sv */
// two-stage synchroniser with rising edge pulse for an oscillator pin
`timescale 1ns/1ps
module scd_edge_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);
  logic meta;
  logic sync;
  logic prev;

  // ----------------------------------------------------------------
  // synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise = sync & ~prev;

endmodule : scd_edge_sync

/* File: hdl/scd_clock_ctrl.sv */
// system clock source select, cpu and peripheral clock enable divider
`timescale 1ns/1ps
//Behaviour
//[R01] select rc oscillator when source select is true, else crystal
//[R02] peripheral clock is selected source divided by two
//[R03] cpu clock divides source per 3-bit code: 8,4,2,1,-,-,16,32
//[R04] codes 100 and 101 refused, divider kept, failure reported
//[R05] wake from sleep restores cpu divider to divide-by-two
//[R06] status shows applied cpu divider code, same encoding
//[R07] status shows whether rc or crystal drives system clock
//[R08] stable flag true only while crystal runs and has settled
//[R09] crystal selected but off: power up, switch once stable
//[R10] rc selected with power-down set: crystal off, else kept powered; code also powers crystal off while sleep_active
//[R11] keep-off setting taken only when a source is selected
//[R12] 2-bit load pull held, 0 adds nothing, 1..3 add picofarads
//[R13] 3-bit bias trim held and driven to oscillator bias control
//[R14] radio must stay idle while rc drives the system clock
//[R15] source and divider changes never truncate any clock pulse
module scd_clock_ctrl #(
  parameter int XTAL_STARTUP_CYCLES = scd_pkg::XTAL_STARTUP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rc_osc_clk,
  input wire logic xtal_osc_clk,
  input wire logic select_strobe,
  input wire logic clock_source_select,
  input wire logic xtal_power_down_request,
  input wire logic xtal_off_when_idle,
  input wire logic rate_strobe,
  input wire logic [2:0] cpu_divider_code,
  input wire logic sleep_active,
  input wire logic wake_from_sleep,
  input wire logic xtal_cfg_strobe,
  input wire logic [1:0] xtal_load_pull,
  input wire logic [2:0] xtal_bias_trim,
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic source_is_rc,
  output logic [2:0] divider_status,
  output logic xtal_stable,
  output logic xtal_power_en,
  output logic select_busy,
  output logic rate_done,
  output logic rate_ok,
  output logic radio_allowed,
  output logic [1:0] xtal_load_cap,
  output logic [2:0] xtal_bias_ctrl
);
  import scd_pkg::*;

  localparam int STW = $clog2(XTAL_STARTUP_CYCLES + 1);
  localparam logic [STW-1:0] ST_LAST = STW'(XTAL_STARTUP_CYCLES);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic rc_tick;
  logic xtal_tick;
  logic target_rc;
  logic active_rc;
  logic pd_policy;
  logic [STW-1:0] st_cnt;
  scd_count_t div_cnt;
  logic periph_ph;
  logic [2:0] div_code;
  logic [2:0] pend_code;
  logic pend_valid;

  // ----------------------------------------------------------------
  // oscillator pins
  // ----------------------------------------------------------------
  scd_edge_sync u_rc_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(rc_osc_clk),
    .rise(rc_tick)
  );

  scd_edge_sync u_xtal_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(xtal_osc_clk),
    .rise(xtal_tick)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire src_tick = active_rc ? rc_tick : xtal_tick; // see [R01]
  wire [4:0] cur_last = scd_div_last(div_code);
  wire cpu_wrap = div_cnt == cur_last;
  // a boundary ends both a cpu and a peripheral period
  wire boundary = src_tick & cpu_wrap & periph_ph; // see [R15]
  wire crystal_idle = target_rc & active_rc & pd_policy;
  wire next_power = ~sleep_active & ~crystal_idle; // see [R10]
  wire st_done = st_cnt == ST_LAST;
  wire want_switch = (target_rc != active_rc)
                     & (target_rc | xtal_stable); // see [R09]
  wire do_switch = want_switch & boundary; // see [R15]
  wire rate_bad = scd_code_bad(cpu_divider_code); // see [R04]
  wire [4:0] next_div_cnt = cpu_wrap ? 5'h00 : 5'(div_cnt + 5'h01);

  assign sys_clk_en = src_tick;
  assign cpu_clk_en = src_tick & cpu_wrap; // see [R03]
  assign periph_clk_en = src_tick & periph_ph; // see [R02]
  assign source_is_rc = active_rc; // see [R07]
  assign divider_status = div_code; // see [R06]
  assign xtal_stable = xtal_power_en & st_done; // see [R08]
  assign select_busy = target_rc != active_rc;
  assign radio_allowed = ~active_rc; // see [R14]

  // ----------------------------------------------------------------
  // source selection and crystal power
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      target_rc <= TARGET_RC_RESET;
      pd_policy <= PD_POLICY_RESET;
    end else if (select_strobe) begin
      target_rc <= clock_source_select; // see [R01]
      // policy sampled only here, not tracked later
      pd_policy <= xtal_power_down_request | xtal_off_when_idle; // see [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_rc <= SRC_RC_RESET;
    end else if (do_switch) begin
      active_rc <= target_rc; // see [R09]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xtal_power_en <= 1'b0;
      st_cnt <= '0;
    end else begin
      xtal_power_en <= next_power;
      if (!xtal_power_en) begin
        st_cnt <= '0;
      end else if (!st_done) begin
        st_cnt <= STW'(st_cnt + 1'b1); // see [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= 5'h00;
      periph_ph <= 1'b0;
    end else if (src_tick) begin
      div_cnt <= next_div_cnt; // see [R03]
      periph_ph <= ~periph_ph; // see [R02]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_code <= DIV_CODE_RESET;
    end else if (boundary && pend_valid) begin
      div_code <= pend_code; // see [R15]
    end
  end

  // ----------------------------------------------------------------
  // rate requests
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_code <= DIV_CODE_RESET;
      pend_valid <= 1'b0;
    end else if (wake_from_sleep) begin
      pend_code <= DIV_CODE_BY2; // see [R05]
      pend_valid <= 1'b1;
    end else if (rate_strobe && !rate_bad) begin
      pend_code <= cpu_divider_code;
      pend_valid <= 1'b1;
    end else if (boundary) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_done <= 1'b0;
      rate_ok <= 1'b0;
    end else begin
      rate_done <= rate_strobe;
      if (rate_strobe) begin
        rate_ok <= ~rate_bad; // see [R04]
      end
    end
  end

  // ----------------------------------------------------------------
  // crystal settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xtal_load_cap <= LOAD_PULL_RESET;
      xtal_bias_ctrl <= BIAS_TRIM_RESET;
    end else if (xtal_cfg_strobe) begin
      xtal_load_cap <= xtal_load_pull; // see [R12]
      xtal_bias_ctrl <= xtal_bias_trim; // see [R13]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rate_reject_a: assert property ( // see [R04]
    @(posedge ref_clk) disable iff (rst)
    rate_strobe && rate_bad |=> rate_done && !rate_ok)
    else $error("bad divider code not refused");

  rate_accept_a: assert property ( // see [R04]
    @(posedge ref_clk) disable iff (rst)
    rate_strobe && !rate_bad && !wake_from_sleep
    |=> rate_ok && pend_valid && pend_code == $past(cpu_divider_code))
    else $error("good divider code not taken");

  rate_keep_a: assert property ( // see [R04]
    @(posedge ref_clk) disable iff (rst)
    rate_strobe && rate_bad && !wake_from_sleep
    |=> pend_code == $past(pend_code))
    else $error("bad divider code changed pending divider");

  wake_div_a: assert property ( // see [R05]
    @(posedge ref_clk) disable iff (rst)
    wake_from_sleep |=> pend_valid && pend_code == DIV_CODE_BY2)
    else $error("wake did not restore divide by two");

  stable_power_a: assert property ( // see [R08]
    @(posedge ref_clk) disable iff (rst)
    $rose(xtal_stable) |-> $past(xtal_power_en, 2))
    else $error("crystal stable without settling time");

  xtal_switch_a: assert property ( // see [R09]
    @(posedge ref_clk) disable iff (rst)
    $fell(active_rc) |-> $past(xtal_stable) && !$past(target_rc))
    else $error("switched to crystal before stable");

  pd_idle_a: assert property ( // see [R10]
    @(posedge ref_clk) disable iff (rst)
    crystal_idle ##1 crystal_idle |-> !xtal_power_en)
    else $error("crystal powered while idle policy set");

  clean_switch_a: assert property ( // see [R15]
    @(posedge ref_clk) disable iff (rst)
    $changed(active_rc) || $changed(div_code)
    |-> $past(boundary) && div_cnt == 5'h00 && !periph_ph)
    else $error("clock change off a period boundary");

  periph_half_a: assert property ( // see [R02]
    @(posedge ref_clk) disable iff (rst)
    periph_clk_en |-> sys_clk_en && periph_ph)
    else $error("peripheral enable not every second tick");

  cpu_period_a: assert property ( // see [R03]
    @(posedge ref_clk) disable iff (rst)
    cpu_clk_en |-> div_cnt == scd_div_last(div_code))
    else $error("cpu enable at wrong count");

  src_rc_a: assert property ( // see [R01]
    @(posedge ref_clk) disable iff (rst)
    active_rc && sys_clk_en |-> rc_tick)
    else $error("system tick not from rc oscillator");

  src_xtal_a: assert property ( // see [R01]
    @(posedge ref_clk) disable iff (rst)
    !active_rc && sys_clk_en |-> xtal_tick)
    else $error("system tick not from crystal");

  status_code_a: assert property ( // see [R06]
    @(posedge ref_clk) disable iff (rst)
    !scd_code_bad(divider_status))
    else $error("applied divider code is invalid");

  radio_block_a: assert property ( // see [R14]
    @(posedge ref_clk) disable iff (rst)
    source_is_rc |-> !radio_allowed)
    else $error("radio allowed while on rc");

  sleep_power_a: assert property ( // see [R10]
    @(posedge ref_clk) disable iff (rst)
    sleep_active |=> !xtal_power_en)
    else $error("crystal powered during sleep");

  policy_hold_a: assert property ( // see [R11]
    @(posedge ref_clk) disable iff (rst)
    !select_strobe |=> $stable(pd_policy))
    else $error("power policy changed without select");

  load_pull_a: assert property ( // see [R12]
    @(posedge ref_clk) disable iff (rst)
    xtal_cfg_strobe |=> xtal_load_cap == $past(xtal_load_pull))
    else $error("load pull setting not applied");

  bias_trim_a: assert property ( // see [R13]
    @(posedge ref_clk) disable iff (rst)
    xtal_cfg_strobe |=> xtal_bias_ctrl == $past(xtal_bias_trim))
    else $error("bias trim setting not applied");

endmodule : scd_clock_ctrl

/* File: tb/scd_osc_model.sv */
// behavioural rc and crystal oscillator sources for the clock block
`timescale 1ns/1ps
module scd_osc_model (
  input wire logic xtal_power_en,
  output logic rc_osc_clk,
  output logic xtal_osc_clk
);
  // ----------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------
  initial rc_osc_clk = 1'b0;
  initial xtal_osc_clk = 1'b0;
  always #135 rc_osc_clk = ~rc_osc_clk;
  // crystal stands still low while unpowered
  always begin
    #160;
    xtal_osc_clk = xtal_power_en ? ~xtal_osc_clk : 1'b0;
  end
endmodule : scd_osc_model

/* File: tb/test_system_clock_source_divider.sv */
// self-checking testbench of the system clock source and divider block
`timescale 1ns/1ps
module test_system_clock_source_divider;
  import scd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rc_osc_clk, xtal_osc_clk;
  logic select_strobe = 1'b0, clock_source_select = 1'b0;
  logic xtal_power_down_request = 1'b0, xtal_off_when_idle = 1'b0;
  logic rate_strobe = 1'b0, sleep_active = 1'b0, wake_from_sleep = 1'b0;
  logic xtal_cfg_strobe = 1'b0;
  logic [2:0] cpu_divider_code = 3'h0, xtal_bias_trim = 3'h0;
  logic [1:0] xtal_load_pull = 2'h0;
  logic sys_clk_en, cpu_clk_en, periph_clk_en, source_is_rc, xtal_stable;
  logic xtal_power_en, select_busy, rate_done, rate_ok, radio_allowed;
  logic [2:0] divider_status, xtal_bias_ctrl;
  logic [1:0] xtal_load_cap;
  int error_cnt = 0;
  int checks_done = 0;
  int div_tab[8] = '{8, 4, 2, 1, 0, 0, 16, 32};
  int n;

  always #25 ref_clk = ~ref_clk;

  scd_osc_model u_osc (.xtal_power_en(xtal_power_en),
    .rc_osc_clk(rc_osc_clk), .xtal_osc_clk(xtal_osc_clk));

  scd_clock_ctrl #(.XTAL_STARTUP_CYCLES(8)) u_dut (.ref_clk(ref_clk),
    .rst(rst), .rc_osc_clk(rc_osc_clk), .xtal_osc_clk(xtal_osc_clk),
    .select_strobe(select_strobe), .clock_source_select(clock_source_select),
    .xtal_power_down_request(xtal_power_down_request),
    .xtal_off_when_idle(xtal_off_when_idle), .rate_strobe(rate_strobe),
    .cpu_divider_code(cpu_divider_code), .sleep_active(sleep_active),
    .wake_from_sleep(wake_from_sleep), .xtal_cfg_strobe(xtal_cfg_strobe),
    .xtal_load_pull(xtal_load_pull), .xtal_bias_trim(xtal_bias_trim),
    .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .source_is_rc(source_is_rc),
    .divider_status(divider_status), .xtal_stable(xtal_stable),
    .xtal_power_en(xtal_power_en), .select_busy(select_busy),
    .rate_done(rate_done), .rate_ok(rate_ok),
    .radio_allowed(radio_allowed), .xtal_load_cap(xtal_load_cap),
    .xtal_bias_ctrl(xtal_bias_ctrl));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic pulse(input int w);
    @(posedge ref_clk);
    case (w)
      0: select_strobe <= 1'b1;
      1: rate_strobe <= 1'b1;
      2: xtal_cfg_strobe <= 1'b1;
      default: wake_from_sleep <= 1'b1;
    endcase
    @(posedge ref_clk);
    select_strobe <= 1'b0;
    rate_strobe <= 1'b0;
    xtal_cfg_strobe <= 1'b0;
    wake_from_sleep <= 1'b0;
    #1;
  endtask : pulse

  function automatic logic [2:0] sel(input int w);
    case (w)
      0: sel = {2'h0, source_is_rc};
      1: sel = {2'h0, xtal_power_en};
      default: sel = divider_status;
    endcase
  endfunction : sel

  task automatic wait_for(input int w, input logic [2:0] v);
    int k;
    k = 0;
    while (sel(w) !== v && k < 3000) begin
      tick();
      k++;
    end
    check({5'h00, sel(w)}, {5'h00, v});
    if (k >= 3000) close_out();
  endtask : wait_for

  // sys ticks from one cpu or periph pulse to the next
  task automatic spacing(input bit per, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while ((per ? periph_clk_en : cpu_clk_en) !== 1'b1 && k < 3000) begin
      tick();
      k++;
    end
    tick();
    while ((per ? periph_clk_en : cpu_clk_en) !== 1'b1 && k < 3000) begin
      if (sys_clk_en === 1'b1) cnt++;
      tick();
      k++;
    end
    cnt++;
    if (k >= 3000) begin
      check(8'h00, 8'h01);
      close_out();
    end
  endtask : spacing

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({7'h00, source_is_rc}, 8'h01);
    check({5'h00, divider_status}, {5'h00, DIV_CODE_RESET});
    check({6'h00, xtal_load_cap}, {6'h00, LOAD_PULL_RESET});
    check({5'h00, xtal_bias_ctrl}, {5'h00, BIAS_TRIM_RESET});
    check({7'h00, xtal_stable}, 8'h00);
    wait_for(0, 3'h0);
    check({7'h00, xtal_stable}, 8'h01);
    check({7'h00, radio_allowed}, 8'h01);
    $display("test reset and auto switch done");
  endtask : t_reset

  task automatic t_rates;
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk);
      cpu_divider_code <= 3'(c);
      pulse(1);
      check({7'h00, rate_done}, 8'h01);
      check({7'h00, rate_ok}, {7'h00, div_tab[c] != 0});
      tick();
      check({7'h00, rate_done}, 8'h00);
      if (div_tab[c] != 0) begin
        wait_for(2, 3'(c));
        spacing(1'b0, n);
        check(8'(n), 8'(div_tab[c]));
        check({7'h00, n == div_tab[c]}, 8'h01);
        spacing(1'b1, n);
        check(8'(n), 8'h02);
      end else begin
        repeat (60) tick();
        check({5'h00, divider_status}, {5'h00, DIV_CODE_BY1});
      end
    end
    $display("test divider codes done");
  endtask : t_rates

  task automatic t_select;
    @(posedge ref_clk);
    clock_source_select <= 1'b1;
    xtal_power_down_request <= 1'b1;
    pulse(0);
    wait_for(0, 3'h1);
    repeat (3) tick();
    check({7'h00, xtal_power_en}, 8'h00);
    check({7'h00, xtal_stable}, 8'h00);
    check({7'h00, radio_allowed}, 8'h00);
    @(posedge ref_clk);
    clock_source_select <= 1'b0;
    xtal_power_down_request <= 1'b0;
    pulse(0);
    check({7'h00, select_busy}, 8'h01);
    wait_for(1, 3'h1);
    wait_for(0, 3'h0);
    check({7'h00, xtal_stable}, 8'h01);
    check({7'h00, select_busy}, 8'h00);
    @(posedge ref_clk);
    clock_source_select <= 1'b1;
    pulse(0);
    wait_for(0, 3'h1);
    @(posedge ref_clk);
    xtal_off_when_idle <= 1'b1;
    repeat (20) tick();
    check({7'h00, xtal_power_en}, 8'h01);
    pulse(0);
    wait_for(1, 3'h0);
    $display("test source select done");
  endtask : t_select

  task automatic t_wake;
    @(posedge ref_clk);
    cpu_divider_code <= DIV_CODE_BY16;
    pulse(1);
    wait_for(2, DIV_CODE_BY16);
    @(posedge ref_clk);
    xtal_off_when_idle <= 1'b0;
    pulse(0);
    wait_for(1, 3'h1);
    @(posedge ref_clk);
    sleep_active <= 1'b1;
    repeat (20) tick();
    check({7'h00, xtal_power_en}, 8'h00);
    @(posedge ref_clk);
    sleep_active <= 1'b0;
    pulse(3);
    wait_for(2, DIV_CODE_BY2);
    spacing(1'b0, n);
    check(8'(n), 8'h02);
    $display("test wake divider done");
  endtask : t_wake

  task automatic t_cfg;
    for (int p = 0; p < 4; p++) begin
      @(posedge ref_clk);
      xtal_load_pull <= 2'(p);
      xtal_bias_trim <= 3'(7 - p);
      pulse(2);
      tick();
      check({6'h00, xtal_load_cap}, 8'(p));
      check({5'h00, xtal_bias_ctrl}, 8'(7 - p));
    end
    @(posedge ref_clk);
    xtal_load_pull <= 2'h1;
    xtal_bias_trim <= 3'h0;
    repeat (3) tick();
    check({6'h00, xtal_load_cap}, 8'h03);
    check({5'h00, xtal_bias_ctrl}, 8'h04);
    $display("test crystal config done");
  endtask : t_cfg

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    tick();
    t_reset();
    t_rates();
    t_select();
    t_wake();
    t_cfg();
    close_out();
  end
endmodule : test_system_clock_source_divider
